// >>> verilog/fcp_panel.sv
// Contract
// - confirm press: rotate all digits ten seconds
// - pass: show pass word three seconds
// - fail: show fail word, error, halt
// - post-test screens in fixed order
// - no signal or unreadable nav shows codes
// - test suspends pulse accumulation seventeen seconds
// - range is ground speed over hourly flow
// - fuel to destination is flow times ete
// - reserve is remaining minus fuel to destination
// - endurance from remaining and flow, hours minutes
// - flow readout resolution by magnitude and units
// - used accumulates, zeroed at entry
// - remaining is start fuel minus used
// - flow left, selector has priority right
// - remaining and used kept in nonvolatile store
// - capacity caps every fuel entry
// - full, confirm, remaining start 15 s countdown
// - capacity edit with accelerating up/down steps
// - confirm stores capacity, returns to run
// - view switch shows used or remaining
// - any fuel entry zeroes used
`timescale 1ns/1ps
module fcp_panel #(
    parameter int          QW          = 20,
    parameter int          SEC_CYCLES  = fcp_pkg::SEC_CYCLES,
    parameter logic [15:0] SW_VERSION  = 16'h0101  // arbitrary value
) (
    input  wire logic          sys_clk_i,
    input  wire logic          arst_n_i,
    input  wire logic [1:0]    flow_pulse_i,
    input  wire logic          confirm_btn_i,
    input  wire logic          view_rem_i,
    input  wire logic          view_used_i,
    input  wire logic          fill_full_i,
    input  wire logic [2:0]    selector_i,
    input  wire logic          twin_i,
    input  wire logic          weight_units_i,
    input  wire logic [1:0]    units_code_i,
    input  wire logic [15:0]   k_factor0_i,
    input  wire logic [15:0]   k_factor1_i,
    input  wire logic [15:0]   ground_speed_i,
    input  wire logic [QW-1:0] dist_waypoint_i,
    input  wire logic [QW-1:0] dist_final_i,
    input  wire logic          dist_final_valid_i,
    input  wire logic [15:0]   ete_waypoint_min_i,
    input  wire logic [15:0]   ete_final_min_i,
    input  wire logic          nav_present_i,
    input  wire logic          nav_decode_ok_i,
    input  wire logic [3:0]    nav_type_i,
    input  wire logic          self_test_fail_i,
    input  wire logic [7:0]    self_test_err_i,
    input  wire logic          nvm_valid_i,
    input  wire logic [QW-1:0] nvm_rem_i,
    input  wire logic [QW-1:0] nvm_used_i,
    input  wire logic [QW-1:0] nvm_cap_i,
    output fcp_pkg::fcp_sym_t  left_sym_o,
    output logic [QW-1:0]      left_val_o,
    output logic               left_dp_o,
    output fcp_pkg::fcp_sym_t  right_sym_o,
    output logic [QW-1:0]      right_val_o,
    output logic               right_dp_o,
    output logic               right_neg_o,
    output logic               halted_o,
    output logic               nvm_wr_o,
    output logic [QW-1:0]      nvm_rem_o,
    output logic [QW-1:0]      nvm_used_o,
    output logic [QW-1:0]      nvm_cap_o
);
    localparam int FAST_CYCLES = SEC_CYCLES / fcp_pkg::FAST_PER_SEC;
    localparam int IW = fcp_pkg::IN_W;

    typedef struct packed {
        logic [IW-1:0]        s1;
        logic [IW-1:0]        s2;
        logic [IW-1:0]        s3;
        logic [IW-1:0]        inp;
        logic [IW-1:0]        inp_d;
        fcp_pkg::fcp_state_t  st;
        logic                 init_done;
        logic [31:0]          fast_cnt;
        logic [3:0]           tenth;
        logic [7:0]           sec_cnt;
        logic [7:0]           susp_cnt;
        logic [15:0]          pcnt0;
        logic [15:0]          pcnt1;
        logic [15:0]          pacc0;
        logic [15:0]          pacc1;
        logic [QW-1:0]        flow0;
        logic [QW-1:0]        flow1;
        logic [QW-1:0]        start;
        logic [QW-1:0]        used;
        logic [QW-1:0]        cap;
        logic [QW-1:0]        edit;
        logic [7:0]           hold_steps;
        logic [3:0]           step_div;
        logic [7:0]           err;
        fcp_pkg::fcp_sym_t    left_sym;
        logic [QW-1:0]        left_val;
        logic                 left_dp;
        fcp_pkg::fcp_sym_t    right_sym;
        logic [QW-1:0]        right_val;
        logic                 right_dp;
        logic                 right_neg;
        logic                 nvm_wr;
        logic [QW-1:0]        nvm_rem;
        logic [QW-1:0]        nvm_used;
    } fcp_regs_t;

    fcp_regs_t r_reg;
    fcp_regs_t r_next;

    logic          fast;
    logic          sec;
    logic          tmr_done;
    logic [IW-1:0] rise;
    logic          cnt0;
    logic          cnt1;
    logic          inc0;
    logic          inc1;
    logic          susp;
    logic [QW-1:0] rem_now;
    logic [QW-1:0] flow_tot;
    logic [31:0]   q_flow0;
    logic [31:0]   q_flow1;
    logic [31:0]   q_end;
    logic [31:0]   q_rng;
    logic [31:0]   q_fdest;
    logic [31:0]   q_lbs;
    logic [15:0]   ete_sel;
    logic [QW-1:0] dist_sel;
    logic          step;

    function automatic logic [31:0] fcp_div(input logic [31:0] a, input logic [31:0] b);
        fcp_div = (b == 32'h0) ? 32'h0 : a / b;
    endfunction : fcp_div

    function automatic logic [QW-1:0] fcp_min(input logic [QW-1:0] a, input logic [QW-1:0] b);
        fcp_min = (a < b) ? a : b;
    endfunction : fcp_min

    always_comb begin
        r_next = r_reg;
        // three-flop synchroniser; a change counts once the 2nd and 3rd agree
        r_next.s1 = {fill_full_i, view_used_i, view_rem_i, confirm_btn_i, flow_pulse_i};
        r_next.s2 = r_reg.s1;
        r_next.s3 = r_reg.s2;
        r_next.inp = (r_reg.s2 & r_reg.s3) | (r_reg.inp & (r_reg.s2 | r_reg.s3));
        r_next.inp_d = r_reg.inp;
        r_next.nvm_wr = 1'b0;
        rise = r_reg.inp & ~r_reg.inp_d;

        fast = (r_reg.fast_cnt == 32'(FAST_CYCLES - 1));
        r_next.fast_cnt = fast ? 32'h0 : r_reg.fast_cnt + 32'h1;
        sec = fast && (r_reg.tenth == 4'(fcp_pkg::FAST_PER_SEC - 1));
        if (fast) begin
            r_next.tenth = sec ? 4'h0 : r_reg.tenth + 4'h1;
        end
        tmr_done = sec && (r_reg.sec_cnt == 8'h01);
        if (sec && r_reg.sec_cnt != 8'h00) begin
            r_next.sec_cnt = r_reg.sec_cnt - 8'h01;
        end

        // pulses are dropped while the test holds the suspend timer
        susp = (r_reg.susp_cnt != 8'h00);
        if (sec && susp) begin
            r_next.susp_cnt = r_reg.susp_cnt - 8'h01;
        end
        // a failed unit stops counting fuel
        susp = susp || (r_reg.st == fcp_pkg::ST_FAIL);
        cnt0 = rise[fcp_pkg::IN_PULSE0] && !susp;
        cnt1 = rise[fcp_pkg::IN_PULSE1] && !susp && twin_i;
        // scale factor is pulses per tenth of a fuel unit
        inc0 = (k_factor0_i != 16'h0) && (r_reg.pacc0 >= k_factor0_i);
        inc1 = (k_factor1_i != 16'h0) && (r_reg.pacc1 >= k_factor1_i);
        r_next.pacc0 = (inc0 ? r_reg.pacc0 - k_factor0_i : r_reg.pacc0) + {15'h0, cnt0};
        r_next.pacc1 = (inc1 ? r_reg.pacc1 - k_factor1_i : r_reg.pacc1) + {15'h0, cnt1};
        r_next.used = r_reg.used + QW'(inc0) + QW'(inc1);
        r_next.pcnt0 = r_reg.pcnt0 + {15'h0, cnt0};
        r_next.pcnt1 = r_reg.pcnt1 + {15'h0, cnt1};
        // hourly flow in tenths from one second of pulses
        q_flow0 = fcp_div(32'(r_reg.pcnt0) * 32'(fcp_pkg::SEC_PER_HOUR), 32'(k_factor0_i));
        q_flow1 = fcp_div(32'(r_reg.pcnt1) * 32'(fcp_pkg::SEC_PER_HOUR), 32'(k_factor1_i));
        if (sec) begin
            r_next.flow0 = q_flow0[QW-1:0];
            r_next.flow1 = q_flow1[QW-1:0];
            r_next.pcnt0 = {15'h0, cnt0};
            r_next.pcnt1 = {15'h0, cnt1};
        end
        if (r_reg.used != r_next.used) begin
            r_next.nvm_wr = 1'b1;
        end

        rem_now = (r_reg.start >= r_reg.used) ? r_reg.start - r_reg.used : '0;
        flow_tot = r_reg.flow0 + (twin_i ? r_reg.flow1 : '0);
        ete_sel = dist_final_valid_i ? ete_final_min_i : ete_waypoint_min_i;
        dist_sel = dist_final_valid_i ? dist_final_i : dist_waypoint_i;
        q_end = fcp_div(32'(rem_now) * 32'(fcp_pkg::MIN_PER_HOUR), 32'(flow_tot));
        q_rng = fcp_div(32'(ground_speed_i) * 32'h64, 32'(flow_tot));
        q_fdest = fcp_div(32'(flow_tot) * 32'(ete_sel), 32'(fcp_pkg::MIN_PER_HOUR));
        q_lbs = 32'(flow_tot) / 32'ha;

        step = 1'b0;
        case (r_reg.st)
            fcp_pkg::ST_RUN: begin
                if (!r_reg.init_done) begin
                    // totals survive power loss; restored once after reset
                    r_next.init_done = 1'b1;
                    if (nvm_valid_i) begin
                        r_next.cap = nvm_cap_i;
                        r_next.start = nvm_rem_i + nvm_used_i;
                        r_next.used = nvm_used_i;
                    end
                end else if (rise[fcp_pkg::IN_CONFIRM]) begin
                    if (r_reg.inp[fcp_pkg::IN_FULL] && r_reg.inp[fcp_pkg::IN_REM]) begin
                        r_next.st = fcp_pkg::ST_PROG_CNT;
                        r_next.sec_cnt = fcp_pkg::COUNTDOWN_S;
                    end else if (r_reg.inp[fcp_pkg::IN_FULL]) begin
                        // full-tank entry is capped by capacity by construction
                        r_next.start = r_reg.cap;
                        r_next.used = '0;
                        r_next.nvm_wr = 1'b1;
                    end else if (!r_reg.inp[fcp_pkg::IN_REM] && !r_reg.inp[fcp_pkg::IN_USED]) begin
                        r_next.st = fcp_pkg::ST_TEST_ROT;
                        r_next.sec_cnt = fcp_pkg::TEST_ROTATE_S;
                        r_next.susp_cnt = fcp_pkg::SUSPEND_S;
                    end
                end
            end
            fcp_pkg::ST_TEST_ROT: begin
                if (tmr_done) begin
                    if (self_test_fail_i) begin
                        r_next.st = fcp_pkg::ST_FAIL;
                        r_next.err = self_test_err_i;
                    end else begin
                        r_next.st = fcp_pkg::ST_TEST_PASS;
                        r_next.sec_cnt = fcp_pkg::PASS_S;
                    end
                end
            end
            fcp_pkg::ST_TEST_PASS: begin
                if (tmr_done) begin
                    r_next.st = fcp_pkg::ST_SCR_K;
                    r_next.sec_cnt = fcp_pkg::SCREEN_S;
                end
            end
            // only a reset leaves the failed state
            fcp_pkg::ST_FAIL: begin
                r_next.st = fcp_pkg::ST_FAIL;
            end
            fcp_pkg::ST_SCR_K, fcp_pkg::ST_SCR_K2, fcp_pkg::ST_SCR_NAV,
            fcp_pkg::ST_SCR_DIST, fcp_pkg::ST_SCR_CAP, fcp_pkg::ST_SCR_VER: begin
                if (tmr_done) begin
                    r_next.sec_cnt = fcp_pkg::SCREEN_S;
                    case (r_reg.st)
                        fcp_pkg::ST_SCR_K:
                            r_next.st = twin_i ? fcp_pkg::ST_SCR_K2 : fcp_pkg::ST_SCR_NAV;
                        fcp_pkg::ST_SCR_K2:   r_next.st = fcp_pkg::ST_SCR_NAV;
                        fcp_pkg::ST_SCR_NAV:  r_next.st = fcp_pkg::ST_SCR_DIST;
                        fcp_pkg::ST_SCR_DIST: r_next.st = fcp_pkg::ST_SCR_CAP;
                        fcp_pkg::ST_SCR_CAP:  r_next.st = fcp_pkg::ST_SCR_VER;
                        default:              r_next.st = fcp_pkg::ST_RUN;
                    endcase
                end
            end
            fcp_pkg::ST_PROG_CNT: begin
                if (!r_reg.inp[fcp_pkg::IN_FULL]) begin
                    r_next.st = fcp_pkg::ST_RUN;
                end else if (tmr_done) begin
                    r_next.st = fcp_pkg::ST_PROG_EDIT;
                    r_next.edit = r_reg.cap;
                    r_next.hold_steps = 8'h00;
                    r_next.step_div = 4'h0;
                end
            end
            fcp_pkg::ST_PROG_EDIT: begin
                if (rise[fcp_pkg::IN_CONFIRM]) begin
                    r_next.st = fcp_pkg::ST_RUN;
                    r_next.cap = r_reg.edit;
                    // lowering capacity pulls remaining fuel down to it
                    if (rem_now > r_reg.edit) begin
                        r_next.start = r_reg.edit + r_reg.used;
                    end
                    r_next.nvm_wr = 1'b1;
                end else if (r_reg.inp[fcp_pkg::IN_REM] ^ r_reg.inp[fcp_pkg::IN_USED]) begin
                    // slow steps first, then one per tenth while held
                    if (fast) begin
                        if (r_reg.hold_steps >= fcp_pkg::STEP_ACCEL_STEPS) begin
                            step = 1'b1;
                        end else if (r_reg.step_div == fcp_pkg::STEP_SLOW_TICKS - 4'h1) begin
                            step = 1'b1;
                            r_next.step_div = 4'h0;
                        end else begin
                            r_next.step_div = r_reg.step_div + 4'h1;
                        end
                    end
                    if (step) begin
                        if (r_reg.hold_steps != 8'hff) begin
                            r_next.hold_steps = r_reg.hold_steps + 8'h01;
                        end
                        if (r_reg.inp[fcp_pkg::IN_REM] && r_reg.edit != '1) begin
                            r_next.edit = r_reg.edit + QW'(1);
                        end else if (r_reg.inp[fcp_pkg::IN_USED] && r_reg.edit != '0) begin
                            r_next.edit = r_reg.edit - QW'(1);
                        end
                    end
                end else begin
                    r_next.hold_steps = 8'h00;
                    r_next.step_div = 4'h0;
                end
            end
            default: r_next.st = fcp_pkg::ST_RUN;
        endcase

        // flow always on the left in normal operation
        r_next.left_sym = fcp_pkg::FCP_SYM_NUM;
        r_next.left_dp = 1'b0;
        if (weight_units_i) begin
            r_next.left_val = (q_lbs > 32'h3e7) ? QW'((q_lbs / 32'ha) * 32'ha) : QW'(q_lbs);
        end else if (flow_tot < QW'(1000)) begin
            r_next.left_val = flow_tot;
            r_next.left_dp = 1'b1;
        end else begin
            r_next.left_val = QW'(32'(flow_tot) / 32'ha);
        end
        r_next.right_sym = fcp_pkg::FCP_SYM_NUM;
        r_next.right_dp = 1'b1;
        r_next.right_neg = 1'b0;
        r_next.right_val = '0;
        case (selector_i)
            fcp_pkg::SEL_ENDUR: begin
                r_next.right_sym = fcp_pkg::FCP_SYM_TIME;
                r_next.right_dp = 1'b0;
                r_next.right_val = QW'((q_end / 32'(fcp_pkg::MIN_PER_HOUR))
                    * 32'(fcp_pkg::TIME_HOUR_POS) + q_end % 32'(fcp_pkg::MIN_PER_HOUR));
            end
            fcp_pkg::SEL_RANGE:   r_next.right_val = QW'(q_rng);
            fcp_pkg::SEL_FDEST:   r_next.right_val = QW'(q_fdest);
            fcp_pkg::SEL_RESERVE: begin
                r_next.right_neg = 32'(rem_now) < q_fdest;
                r_next.right_val = r_next.right_neg ? QW'(q_fdest - 32'(rem_now))
                                                    : QW'(32'(rem_now) - q_fdest);
            end
            default: begin
                if (r_reg.inp[fcp_pkg::IN_USED]) begin
                    r_next.right_val = r_reg.used;
                end else if (r_reg.inp[fcp_pkg::IN_REM]) begin
                    r_next.right_val = rem_now;
                end else begin
                    r_next.right_sym = fcp_pkg::FCP_SYM_BLANK;
                end
            end
        endcase

        case (r_reg.st)
            fcp_pkg::ST_RUN: r_next.right_sym = r_next.right_sym;
            fcp_pkg::ST_TEST_ROT: begin
                r_next.left_sym = fcp_pkg::FCP_SYM_ROTATE;
                r_next.right_sym = fcp_pkg::FCP_SYM_ROTATE;
                r_next.left_val = QW'(r_reg.tenth);
                r_next.right_val = QW'(r_reg.tenth);
            end
            fcp_pkg::ST_TEST_PASS: begin
                r_next.left_sym = fcp_pkg::FCP_SYM_BLANK;
                r_next.right_sym = fcp_pkg::FCP_SYM_PASS;
            end
            fcp_pkg::ST_FAIL: begin
                r_next.left_sym = fcp_pkg::FCP_SYM_FAIL;
                r_next.right_sym = fcp_pkg::FCP_SYM_NUM;
                r_next.right_val = QW'(r_reg.err);
                r_next.right_dp = 1'b0;
            end
            fcp_pkg::ST_SCR_K: begin
                r_next.left_val = QW'(k_factor0_i);
                r_next.right_sym = fcp_pkg::FCP_SYM_UNITS;
                r_next.right_val = QW'(units_code_i);
            end
            fcp_pkg::ST_SCR_K2: begin
                r_next.left_sym = fcp_pkg::FCP_SYM_BLANK;
                r_next.right_val = QW'(k_factor1_i);
                r_next.right_dp = 1'b0;
            end
            fcp_pkg::ST_SCR_NAV, fcp_pkg::ST_SCR_DIST: begin
                if (r_reg.st == fcp_pkg::ST_SCR_NAV) begin
                    r_next.left_sym = nav_present_i ? fcp_pkg::FCP_SYM_NAV_TYPE
                                                    : fcp_pkg::FCP_SYM_NAV_ABSENT;
                    r_next.left_val = QW'(nav_type_i);
                    r_next.right_sym = fcp_pkg::FCP_SYM_BLANK;
                end else begin
                    r_next.left_sym = fcp_pkg::FCP_SYM_BLANK;
                    r_next.right_sym = nav_present_i ? fcp_pkg::FCP_SYM_NUM
                                                     : fcp_pkg::FCP_SYM_BLANK;
                    r_next.right_val = dist_sel;
                end
                if (nav_present_i && !nav_decode_ok_i) begin
                    r_next.right_sym = fcp_pkg::FCP_SYM_NAV_UNREAD;
                end
            end
            fcp_pkg::ST_SCR_CAP, fcp_pkg::ST_PROG_EDIT: begin
                r_next.left_sym = fcp_pkg::FCP_SYM_CAPACITY;
                r_next.right_val = (r_reg.st == fcp_pkg::ST_SCR_CAP) ? r_reg.cap : r_reg.edit;
            end
            fcp_pkg::ST_SCR_VER: begin
                r_next.left_sym = fcp_pkg::FCP_SYM_VERSION;
                r_next.right_val = QW'(SW_VERSION);
                r_next.right_dp = 1'b0;
            end
            default: begin
                r_next.left_val = QW'(r_reg.sec_cnt);
                r_next.left_dp = 1'b0;
                r_next.right_sym = fcp_pkg::FCP_SYM_BLANK;
            end
        endcase
        r_next.nvm_rem = (r_next.start >= r_next.used) ? r_next.start - r_next.used : '0;
        r_next.nvm_used = r_next.used;
    end

    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            r_reg <= '0;
        end else begin
            r_reg <= r_next;
        end
    end

    assign left_sym_o  = r_reg.left_sym;
    assign left_val_o  = r_reg.left_val;
    assign left_dp_o   = r_reg.left_dp;
    assign right_sym_o = r_reg.right_sym;
    assign right_val_o = r_reg.right_val;
    assign right_dp_o  = r_reg.right_dp;
    assign right_neg_o = r_reg.right_neg;
    assign halted_o    = (r_reg.st == fcp_pkg::ST_FAIL);
    assign nvm_wr_o    = r_reg.nvm_wr;
    assign nvm_rem_o   = r_reg.nvm_rem;
    assign nvm_used_o  = r_reg.nvm_used;
    assign nvm_cap_o   = r_reg.cap;
endmodule : fcp_panel

// >>> shared/fcp_pkg.sv
package fcp_pkg;
    localparam int     CLK_PERIOD_NS = 10;
    localparam longint SEC_NS        = 64'd1000000000;
    localparam int     SEC_CYCLES    = int'(SEC_NS / CLK_PERIOD_NS);
    localparam int     FAST_PER_SEC  = 10;
    localparam int     SEC_PER_HOUR  = 3600;
    localparam int     MIN_PER_HOUR  = 60;
    localparam int     TIME_HOUR_POS = 100;
    // whole seconds, counted on the one-second enable
    localparam logic [7:0] TEST_ROTATE_S = 8'h0a;
    localparam logic [7:0] PASS_S        = 8'h03;
    localparam logic [7:0] SUSPEND_S     = 8'h11;
    localparam logic [7:0] COUNTDOWN_S   = 8'h0f;
    localparam logic [7:0] SCREEN_S      = 8'h02;
    // edit stepping: slow steps every few tenths, then every tenth
    localparam logic [3:0] STEP_SLOW_TICKS = 4'h4;
    localparam logic [7:0] STEP_ACCEL_STEPS = 8'h0a;
    // synchronised input bit positions
    localparam int IN_PULSE0  = 0;
    localparam int IN_PULSE1  = 1;
    localparam int IN_CONFIRM = 2;
    localparam int IN_REM     = 3;
    localparam int IN_USED    = 4;
    localparam int IN_FULL    = 5;
    localparam int IN_W       = 6;
    // rotary selector positions
    localparam logic [2:0] SEL_NONE    = 3'h0;
    localparam logic [2:0] SEL_ENDUR   = 3'h1;
    localparam logic [2:0] SEL_RANGE   = 3'h2;
    localparam logic [2:0] SEL_FDEST   = 3'h3;
    localparam logic [2:0] SEL_RESERVE = 3'h4;

    typedef enum logic [3:0] {
        FCP_SYM_BLANK,
        FCP_SYM_NUM,
        FCP_SYM_TIME,
        FCP_SYM_ROTATE,
        FCP_SYM_PASS,
        FCP_SYM_FAIL,
        FCP_SYM_UNITS,
        FCP_SYM_NAV_TYPE,
        FCP_SYM_NAV_ABSENT,
        FCP_SYM_NAV_UNREAD,
        FCP_SYM_CAPACITY,
        FCP_SYM_VERSION
    } fcp_sym_t;

    typedef enum {
        ST_RUN, ST_TEST_ROT, ST_TEST_PASS, ST_FAIL, ST_SCR_K, ST_SCR_K2,
        ST_SCR_NAV, ST_SCR_DIST, ST_SCR_CAP, ST_SCR_VER, ST_PROG_CNT, ST_PROG_EDIT
    } fcp_state_t;
endpackage : fcp_pkg

// >>> verif/fcp_panel_asserts.sv
`timescale 1ns/1ps
module fcp_panel_chk #(parameter int QW = 20, parameter int SEC_CYCLES = 100) (
    input wire logic          sys_clk_i,
    input wire logic          arst_n_i,
    input fcp_pkg::fcp_sym_t  left_sym_o,
    input fcp_pkg::fcp_sym_t  right_sym_o,
    input wire logic          halted_o,
    input wire logic          nvm_wr_o,
    input wire logic [QW-1:0] nvm_rem_o,
    input wire logic [QW-1:0] nvm_used_o,
    input wire logic [QW-1:0] nvm_cap_o
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!arst_n_i);
    // the first second of the rotate may be short: timers run on a free tick
    localparam int ROT_LO = 9 * SEC_CYCLES - 1, ROT_HI = 10 * SEC_CYCLES + 1;
    logic [15:0]       run_reg;
    logic [3:0]        sym_reg;
    always_ff @(posedge sys_clk_i or negedge arst_n_i)
        if (!arst_n_i) {run_reg, sym_reg} <= '0;
        else {run_reg, sym_reg} <= {(left_sym_o == sym_reg) ? run_reg + 16'h1 : 16'h1, left_sym_o};
    a_rot_len: assert property (sym_reg == fcp_pkg::FCP_SYM_ROTATE && left_sym_o != sym_reg
        |-> run_reg inside {[ROT_LO:ROT_HI]}) else $error("rotate time");
    a_rot_next: assert property (sym_reg == fcp_pkg::FCP_SYM_ROTATE && left_sym_o != sym_reg
        |-> left_sym_o == fcp_pkg::FCP_SYM_FAIL || right_sym_o == fcp_pkg::FCP_SYM_PASS)
        else $error("no verdict");
    a_units_next: assert property ($past(right_sym_o) == fcp_pkg::FCP_SYM_PASS
        && right_sym_o != fcp_pkg::FCP_SYM_PASS |-> right_sym_o == fcp_pkg::FCP_SYM_UNITS)
        else $error("no units screen");
    a_halt_fail: assert property (halted_o |-> ##1 left_sym_o == fcp_pkg::FCP_SYM_FAIL)
        else $error("halt without fail word");
    a_halt_stay: assert property (halted_o |=> halted_o) else $error("halt lost");
    a_cap_bound: assert property (nvm_wr_o |-> nvm_rem_o <= nvm_cap_o) else $error("over cap");
    a_test_hold: assert property (left_sym_o == fcp_pkg::FCP_SYM_ROTATE && sym_reg == left_sym_o
        |-> $stable(nvm_used_o)) else $error("count during test");
    a_used_rem: assert property ($past(nvm_used_o) != 0 && nvm_used_o == $past(nvm_used_o) + 1'b1
        |-> nvm_rem_o + 1'b1 == $past(nvm_rem_o)) else $error("remaining not tracking");
    c_rotate: cover property (left_sym_o == fcp_pkg::FCP_SYM_ROTATE);
    c_halt: cover property (halted_o);
    c_write: cover property (nvm_wr_o);
endmodule : fcp_panel_chk
bind fcp_panel fcp_panel_chk #(.QW(QW), .SEC_CYCLES(SEC_CYCLES)) i_fcp_panel_chk (.*);

// >>> verif/fcp_xdcr_model.sv
`timescale 1ns/1ps
module fcp_xdcr_model #(parameter int HALF = 10) (
    input  wire logic sys_clk_i,
    input  wire logic run_i,
    output logic      pulse_o
);
    // fixed rate stands for steady flow; a stalled rotor just stops the pulses
    int cnt = 0;
    always @(posedge sys_clk_i) cnt <= (!run_i || cnt == HALF - 1) ? 0 : cnt + 1;
    always @(posedge sys_clk_i) pulse_o <= run_i && (pulse_o ^ (cnt == HALF - 1));
endmodule : fcp_xdcr_model

// >>> verif/tb_top.sv
`timescale 1ns/1ps
`define CK(a, b) begin n_tests++; if ((a) !== (b)) begin n_errors++; \
    $display("wrong value t=%0t got %h exp %h", $time, a, b); end end
module tb_top;
    typedef struct packed {logic [2:0] s; logic [1:0] v; logic [3:0] y; logic [19:0] d;} fcp_row_t;
    fcp_row_t rows [6] = '{'{3'h1, 2'h0, 4'h2, 20'h0}, '{3'h2, 2'h0, 4'h1, 20'h0},
        '{3'h3, 2'h0, 4'h1, 20'h0}, '{3'h4, 2'h2, 4'h1, 20'h64}, '{3'h0, 2'h2, 4'h1, 20'h0a},
        '{3'h0, 2'h1, 4'h1, 20'h64}};
    logic clk = 0, rst_n = 0, run = 0, cf = 0, vr = 0, vu = 0, ff = 0, tf = 0, p0, ldp, hl, wr;
    logic [2:0] sel = 3'h0;
    fcp_pkg::fcp_sym_t ls, rs;
    logic [19:0] rv, nr, nu, nc, lv, df = 20'h3e8, nvr = 20'h64, nvu = 20'h0a, nvc = 20'h1f4;
    logic tw = 0, wu = 0, dfv = 1, np = 0, nd = 1, nv = 1;
    logic [15:0] k0 = 16'h2, k1 = 16'h2, gs = 16'h78, ef = 16'h3c;
    int n_errors = 0, n_tests = 0;
    fcp_xdcr_model i_fcp_xdcr_model (.sys_clk_i(clk), .run_i(run), .pulse_o(p0));
    fcp_panel #(.SEC_CYCLES(100)) i_fcp_panel (.sys_clk_i(clk), .arst_n_i(rst_n),
        .flow_pulse_i({p0, p0}), .confirm_btn_i(cf), .view_rem_i(vr), .view_used_i(vu),
        .fill_full_i(ff), .selector_i(sel), .twin_i(tw), .weight_units_i(wu),
        .units_code_i(2'h1), .k_factor0_i(k0), .k_factor1_i(k1), .ground_speed_i(gs),
        .dist_waypoint_i(20'h1f4), .dist_final_i(df), .dist_final_valid_i(dfv),
        .ete_waypoint_min_i(16'h1e), .ete_final_min_i(ef), .nav_present_i(np),
        .nav_decode_ok_i(nd), .nav_type_i(4'h1), .self_test_fail_i(tf),
        .self_test_err_i(8'h5a), .nvm_valid_i(nv), .nvm_rem_i(nvr), .nvm_used_i(nvu),
        .nvm_cap_i(nvc), .left_sym_o(ls), .left_val_o(lv), .left_dp_o(ldp),
        .right_sym_o(rs), .right_val_o(rv), .right_dp_o(), .right_neg_o(), .halted_o(hl),
        .nvm_wr_o(wr), .nvm_rem_o(nr), .nvm_used_o(nu), .nvm_cap_o(nc));
    task automatic tk(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tk
    task automatic press;
        cf = 1;
        tk(8);
        cf = 0;
    endtask : press
    task automatic wl(input fcp_pkg::fcp_sym_t s, input bit r = 1'b0);
        for (int i = 0; i < 3000 && (r ? rs : ls) !== s; i++) tk(1);
        `CK(r ? rs : ls, s)
    endtask : wl
    task automatic ww;
        for (int i = 0; i < 500 && wr !== 1'b1; i++) tk(1);
        `CK(wr, 1'b1)
    endtask : ww
    task automatic complete_run;
        $display("errors %0d tests %0d", n_errors, n_tests);
        if (n_errors == 0 && n_tests > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : complete_run
    initial forever #5 clk = ~clk;
    initial begin
        repeat (20000) @(posedge clk);
        n_errors++;
        complete_run;
    end
    initial begin
        tk(12);
        `CK(ls, fcp_pkg::FCP_SYM_BLANK)
        rst_n = 1;
        tk(10);
        foreach (rows[i]) begin
            {sel, vu, vr} = {rows[i].s, rows[i].v};
            tk(10);
            `CK({rs, rv}, {rows[i].y, rows[i].d})
        end
        {sel, vu, vr, ff, cf} = 7'h3;
        ww;
        `CK({nr, nu}, {20'h1f4, 20'h0})
        {ff, cf, run} = 3'h1;
        tk(300);
        `CK({nr + nu, ldp, nu == 20'h0}, {20'h1f4, 2'h0})
        `CK({ldp, lv}, {1'b0, 20'h384})
        sel = 3'h2;
        tk(3);
        `CK(rv, 20'h1)
        sel = 3'h3;
        tk(3);
        `CK(rv, 20'h2328)
        dfv = 0;
        tk(3);
        `CK(rv, 20'h1194)
        press;
        wl(fcp_pkg::FCP_SYM_ROTATE);
        wl(fcp_pkg::FCP_SYM_PASS, 1'b1);
        wl(fcp_pkg::FCP_SYM_NAV_ABSENT);
        wl(fcp_pkg::FCP_SYM_CAPACITY);
        `CK(rv, 20'h1f4)
        wl(fcp_pkg::FCP_SYM_VERSION);
        run = 0;
        tk(250);
        {ff, vr} = 2'h3;
        press;
        wl(fcp_pkg::FCP_SYM_CAPACITY);
        tk(100);
        {vr, cf} = 2'h1;
        ww;
        `CK(nc > 20'h1f4, 1'b1)
        {ff, cf, tf} = 3'h1;
        tk(10);
        press;
        wl(fcp_pkg::FCP_SYM_FAIL);
        `CK({hl, rv}, {1'b1, 20'h5a})
        {rst_n, vr, sel, nvr} = {1'b0, 1'b1, 3'h0, 20'h99};
        tk(2);
        rst_n = 1;
        tk(10);
        `CK({hl, rv}, {1'b0, 20'h99})
        complete_run;
    end
endmodule : tb_top
